// *** hw/iee_consts.svh ***
// constants for the interrupt endpoint event gate
// Overview of operation
// [R1] always-send bit 31 set: send a packet every polling interval.
// [R2] always-send clear: send only when an enabled source has occurred.
// [R3] bit 28 enables one-time-programmable write done as a packet trigger.
// [R4] bits 26,25,24 enable low-power tx start, tx stop, rx events.
// [R5] bit 23 gates the MAC reset timeout event.
// [R6] bit 22 gates the receive FIFO overflow event.
// [R7] bit 21 gates the transmit error event.
// [R8] bit 20 gates the USB status change event.
// [R9] bits 19,18 gate transmitter-off and receiver-off events.
// [R10] bit 17 gates the active-low external transceiver interrupt pin.
// [R11] bit 16 gates the data port event.
// [R12] bit 15 gates the MAC fault event.
// [R13] bits 14,13 gate tx FIFO under-run and overrun events.
// [R14] bit 12 gates the bulk-in frame pending event.
// [R15] bits 11:0 enable one general-purpose pin event each.
// [R16] any flagged change in usb status bits 15:0 raises the usb event.
// [R17] enables reset to zero; bits 30,29,27 read zero, ignore writes.
// [R18] disabled events never trigger a packet but are still recorded.
`ifndef IEE_CONSTS_SVH
`define IEE_CONSTS_SVH
`define IEE_OFS_CTRL 8'h98
`define IEE_OFS_STATUS 8'hA0
`define IEE_OFS_MASK 8'hA4
`define IEE_OFS_PEND 8'hA8
`define IEE_CTRL_WMASK 32'h97FFFFFF
`define IEE_CTRL_RESET 32'h00000000
`define IEE_BIT_ALWAYS 31
`define IEE_BIT_OTP 28
`define IEE_BIT_USB 20
`define IEE_BIT_XCVR 17
`define IEE_IRQ_SENT 0
`define IEE_IRQ_DROPPED 1
`endif

// *** hw/iee_event_gate.sv ***
// interrupt endpoint event gate with axi4-lite register slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "iee_consts.svh"
module iee_event_gate (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic OTP_WRITE_DONE,
  input wire logic TX_LOW_POWER_START,
  input wire logic TX_LOW_POWER_STOP,
  input wire logic RX_LOW_POWER,
  input wire logic MAC_RESET_TIMEOUT,
  input wire logic RX_FIFO_OVERFLOW,
  input wire logic TRANSMIT_ERROR,
  input wire logic [15:0] USB_STATUS_CHANGE,
  input wire logic TRANSMITTER_OFF,
  input wire logic RECEIVER_OFF,
  input wire logic TRANSCEIVER_IRQ_N,
  input wire logic DATA_PORT_EVENT,
  input wire logic MAC_FAULT,
  input wire logic TX_FIFO_UNDERRUN,
  input wire logic TX_FIFO_OVERRUN,
  input wire logic BULK_IN_FRAME_PENDING,
  input wire logic [11:0] PIN_EVENT,
  input wire logic POLL_TICK,
  output logic PACKET_SEND,
  output logic [31:0] PACKET_SOURCES,
  output logic IRQ
);

  logic [31:0] ctrl_q;
  logic [31:0] pend_q;
  logic [31:0] src_raw;
  logic [31:0] src_gated;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  iee_pkg::iee_wr_state_t wr_state_q;
  logic wr_fire;
  logic wr_hit;
  logic rd_fire;
  logic rd_hit;
  logic [31:0] rd_data;
  logic packet_fire;
  logic packet_drop;
  logic usb_event;

  // usb status event is an or over all change flags
  assign usb_event = |USB_STATUS_CHANGE; // R16

  // source vector laid out like the control register
  always_comb begin
    src_raw = 32'h00000000;
    src_raw[`IEE_BIT_OTP] = OTP_WRITE_DONE; // R3
    src_raw[26] = TX_LOW_POWER_START; // R4
    src_raw[25] = TX_LOW_POWER_STOP; // R4
    src_raw[24] = RX_LOW_POWER; // R4
    src_raw[23] = MAC_RESET_TIMEOUT; // R5
    src_raw[22] = RX_FIFO_OVERFLOW; // R6
    src_raw[21] = TRANSMIT_ERROR; // R7
    src_raw[`IEE_BIT_USB] = usb_event; // R8
    src_raw[19] = TRANSMITTER_OFF; // R9
    src_raw[18] = RECEIVER_OFF; // R9
    src_raw[`IEE_BIT_XCVR] = ~TRANSCEIVER_IRQ_N; // R10
    src_raw[16] = DATA_PORT_EVENT; // R11
    src_raw[15] = MAC_FAULT; // R12
    src_raw[14] = TX_FIFO_UNDERRUN; // R13
    src_raw[13] = TX_FIFO_OVERRUN; // R13
    src_raw[12] = BULK_IN_FRAME_PENDING; // R14
    src_raw[11:0] = PIN_EVENT; // R15
  end

  // recorded events seen through their enables; bit 31 is no source
  genvar gi;
  generate
    for (gi = 0; gi < 31; gi++) begin : g_gate
      assign src_gated[gi] = pend_q[gi] & ctrl_q[gi]; // R3 R15
    end
  endgenerate
  assign src_gated[31] = 1'b0;

  // packet goes out on a poll if forced or an enabled event is recorded
  assign packet_fire = POLL_TICK &
    (ctrl_q[`IEE_BIT_ALWAYS] | (|src_gated)); // R1 R2
  assign packet_drop = POLL_TICK & ~packet_fire & (|pend_q);

  // write channel handshakes: accept each side once, in any order
  assign S_AXI_AWREADY = ~aw_got_q & (wr_state_q == iee_pkg::IEE_WR_IDLE);
  assign S_AXI_WREADY = ~w_got_q & (wr_state_q == iee_pkg::IEE_WR_IDLE);
  assign wr_fire = aw_got_q & w_got_q &
    (wr_state_q == iee_pkg::IEE_WR_IDLE);
  assign wr_hit = (aw_addr_q == `IEE_OFS_CTRL) ||
    (aw_addr_q == `IEE_OFS_MASK) || (aw_addr_q == `IEE_OFS_STATUS) ||
    (aw_addr_q == `IEE_OFS_PEND);

  // capture address and data halves
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
    end
  end

  // write response state; unmapped address answers slverr
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      wr_state_q <= iee_pkg::IEE_WR_IDLE;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
    end else begin
      case (wr_state_q)
        iee_pkg::IEE_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= iee_pkg::IEE_WR_RESP;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? iee_pkg::IEE_RESP_OKAY :
              iee_pkg::IEE_RESP_SLVERR;
          end
        end
        iee_pkg::IEE_WR_RESP: begin
          if (S_AXI_BREADY) begin
            wr_state_q <= iee_pkg::IEE_WR_IDLE;
            S_AXI_BVALID <= 1'b0;
          end
        end
        default: wr_state_q <= iee_pkg::IEE_WR_IDLE;
      endcase
    end
  end

  // control register; reserved bits masked off so they stay zero
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= `IEE_CTRL_RESET; // R17
    end else if (wr_fire && aw_addr_q == `IEE_OFS_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b]) begin
          ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8] &
            8'(`IEE_CTRL_WMASK >> (b*8)); // R17
        end
      end
    end
  end

  // interrupt mask, low bits only
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      irq_mask_q <= 2'b00;
    end else if (wr_fire && aw_addr_q == `IEE_OFS_MASK && w_strb_q[0]) begin
      irq_mask_q <= w_data_q[1:0];
    end
  end

  // record every event, enabled or not; a poll that sends clears it
  // set beats clear so an event arriving with the poll is kept
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pend_q <= 32'h00000000;
    end else begin
      pend_q <= ((packet_fire ? 32'h00000000 : pend_q) |
        (src_raw & 32'h7FFFFFFF)); // R18
    end
  end

  // packet outputs: sources reported are the enabled recorded ones
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PACKET_SEND <= 1'b0;
      PACKET_SOURCES <= 32'h00000000;
    end else begin
      PACKET_SEND <= packet_fire; // R1 R2
      if (packet_fire) begin
        PACKET_SOURCES <= src_gated; // R18
      end
    end
  end

  // read side: one read at a time, answer one cycle after address
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  always_comb begin
    rd_hit = 1'b1;
    if (S_AXI_ARADDR[7:2] == `IEE_OFS_CTRL >> 2) begin
      rd_data = ctrl_q;
    end else if (S_AXI_ARADDR[7:2] == `IEE_OFS_STATUS >> 2) begin
      rd_data = {30'h00000000, irq_status_q};
    end else if (S_AXI_ARADDR[7:2] == `IEE_OFS_MASK >> 2) begin
      rd_data = {30'h00000000, irq_mask_q};
    end else if (S_AXI_ARADDR[7:2] == `IEE_OFS_PEND >> 2) begin
      rd_data = pend_q;
    end else begin
      rd_data = 32'h00000000;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= 2'b00;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_data;
      S_AXI_RRESP <= rd_hit ? iee_pkg::IEE_RESP_OKAY :
        iee_pkg::IEE_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // sticky status, cleared by a read; a new event in that cycle wins
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      irq_status_q <= 2'b00;
    end else begin
      irq_status_q <= ((rd_fire &&
        S_AXI_ARADDR[7:2] == `IEE_OFS_STATUS >> 2) ? 2'b00 : irq_status_q)
        | {packet_drop, packet_fire};
    end
  end

  // level interrupt while any unmasked status bit is set
  assign IRQ = |(irq_status_q & irq_mask_q);

  // checks
  always_comb begin
  end
  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  always_comb begin
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  always_send_a: assert property (POLL_TICK && ctrl_q[31] // R1
    |=> PACKET_SEND)
    else $error("always-send poll gave no packet");
  gated_only_a: assert property (PACKET_SEND |-> $past(POLL_TICK) && // R2
    ($past(ctrl_q[31]) || $past(|(pend_q & ctrl_q))))
    else $error("packet without enabled event");
  blocked_poll_a: assert property (POLL_TICK && !ctrl_q[31] && // R2
    (pend_q & ctrl_q & 32'h7FFFFFFF) == 32'h0 |=> !PACKET_SEND)
    else $error("disabled source sent a packet");
  otp_gate_a: assert property (POLL_TICK && pend_q[28] && ctrl_q[28] // R3
    |=> PACKET_SEND && PACKET_SOURCES[28])
    else $error("enabled otp write done sent no packet");
  low_power_a: assert property (POLL_TICK && pend_q[24] && ctrl_q[24] // R4
    |=> PACKET_SEND && PACKET_SOURCES[24])
    else $error("enabled rx low power sent no packet");
  mac_timeout_a: assert property (POLL_TICK && pend_q[23] && ctrl_q[23] // R5
    |=> PACKET_SEND && PACKET_SOURCES[23])
    else $error("enabled mac timeout sent no packet");
  usb_gate_a: assert property (POLL_TICK && pend_q[20] && ctrl_q[20] // R8
    |=> PACKET_SEND && PACKET_SOURCES[20])
    else $error("enabled usb change sent no packet");
  frame_pend_a: assert property (POLL_TICK && pend_q[12] && ctrl_q[12] // R14
    |=> PACKET_SEND && PACKET_SOURCES[12])
    else $error("enabled frame pending sent no packet");
  usb_event_a: assert property (|USB_STATUS_CHANGE && !POLL_TICK // R16
    |=> pend_q[20])
    else $error("usb change not recorded");
  xcvr_pin_a: assert property (!TRANSCEIVER_IRQ_N && !POLL_TICK // R10
    |=> pend_q[17])
    else $error("transceiver pin event lost");
  reserved_a: assert property ((ctrl_q & 32'h68000000) == 32'h0) // R17
    else $error("reserved control bits set");
  record_a: assert property (MAC_FAULT && !ctrl_q[15] && !POLL_TICK // R18
    |=> pend_q[15])
    else $error("disabled event not recorded");
  sources_a: assert property (PACKET_SEND |-> (PACKET_SOURCES & // R15
    ~$past(ctrl_q)) == 32'h0)
    else $error("reported source not enabled");
  // a mask write in the sending cycle may legally drop the line
  irq_level_a: assert property (packet_fire && irq_mask_q[0] && !wr_fire
    |=> IRQ)
    else $error("interrupt not raised");

  forced_c: cover property (POLL_TICK && ctrl_q[31]);
  event_c: cover property (POLL_TICK && !ctrl_q[31] ##1 PACKET_SEND);
  drop_c: cover property (packet_drop);
  wr_c: cover property (wr_fire && aw_addr_q == `IEE_OFS_CTRL);

endmodule // iee_event_gate

// *** hw/iee_pkg.sv ***
// types for the interrupt endpoint event gate
package iee_pkg;
  typedef enum logic [1:0] {
    IEE_RESP_OKAY = 2'b00,
    IEE_RESP_SLVERR = 2'b10
  } iee_resp_t;
  typedef enum logic [0:0] {
    IEE_WR_IDLE = 1'b0,
    IEE_WR_RESP = 1'b1
  } iee_wr_state_t;
endpackage

// *** sim/iee_event_gate_bench.sv ***
// self-checking bench for the interrupt endpoint event gate
`timescale 1ns/1ps
`include "iee_consts.svh"
module iee_event_gate_bench;
  localparam logic [1:0] OK = iee_pkg::IEE_RESP_OKAY;
  localparam logic [1:0] ERR = iee_pkg::IEE_RESP_SLVERR;
  logic clk, rstn, awv, wv, bry, arv, rry;
  logic [7:0] awa, ara;
  logic [31:0] wd, ev;
  logic aw_r, w_r, bv, ar_r, rv, irq, psend, pt;
  logic [1:0] br, rr;
  logic [31:0] rd, psrc;
  int errors, checks_done;

  iee_event_gate dut (
    .CLK_SYS(clk), .RESETN(rstn),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_r),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(w_r), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(ar_r), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .OTP_WRITE_DONE(ev[28]), .TX_LOW_POWER_START(ev[26]),
    .TX_LOW_POWER_STOP(ev[25]), .RX_LOW_POWER(ev[24]),
    .MAC_RESET_TIMEOUT(ev[23]), .RX_FIFO_OVERFLOW(ev[22]),
    .TRANSMIT_ERROR(ev[21]),
    .USB_STATUS_CHANGE({ev[20], 14'h0000, ev[30]}),
    .TRANSMITTER_OFF(ev[19]), .RECEIVER_OFF(ev[18]),
    .TRANSCEIVER_IRQ_N(!ev[17]), .DATA_PORT_EVENT(ev[16]),
    .MAC_FAULT(ev[15]), .TX_FIFO_UNDERRUN(ev[14]),
    .TX_FIFO_OVERRUN(ev[13]), .BULK_IN_FRAME_PENDING(ev[12]),
    .PIN_EVENT(ev[11:0]), .POLL_TICK(pt), .PACKET_SEND(psend),
    .PACKET_SOURCES(psrc), .IRQ(irq)
  );

  iee_host_model host (
    .CLK_SYS(clk), .RESETN(rstn), .POLL_TICK(pt),
    .PACKET_SEND(psend), .PACKET_SOURCES(psrc)
  );

  // free-running 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic gave_up(input int n);
    if (n >= 60) begin
      errors++;
      $display("unexpected at %0t: bus answer never came", $time);
      tally_and_finish();
    end
  endtask

  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && aw_r) awv <= 1'b0;
      if (wv && w_r) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 60);
    bry <= 1'b0;
    gave_up(n);
    chk({30'h0, br}, {30'h0, er});
  endtask

  // read: data and response taken at the edge that sees rvalid
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && ar_r) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 60);
    rry <= 1'b0;
    gave_up(n);
    chk(rd, e);
    chk({30'h0, rr}, {30'h0, er});
  endtask

  // one-cycle event pulse on the source at control bit b
  task automatic pulse(input int b);
    @(posedge clk);
    ev <= 32'h00000001 << b;
    @(posedge clk);
    ev <= 32'h00000000;
    @(posedge clk);
  endtask

  // one polling interval; gap varies so the host is fast and slow
  task automatic poll_chk(input logic [31:0] n, input logic [31:0] s,
                          input bit cs);
    int s0;
    s0 = host.sends;
    host.poll(s0 % 4);
    chk(32'(host.sends - s0), n);
    if (cs) chk(host.last_src, s);
  endtask

  task automatic irq_chk(input logic e);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    {awv, wv, bry, arv, rry} = 5'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h00000000;
    ev = 32'h00000000;
    rstn = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rdc(`IEE_OFS_CTRL, 32'h00000000, OK);
    wr(`IEE_OFS_CTRL, 32'hFFFFFFFF, OK);
    rdc(`IEE_OFS_CTRL, 32'h97FFFFFF, OK);
    wr(8'h9C, 32'hFFFFFFFF, ERR);
    rdc(8'h9C, 32'h00000000, ERR);
    wr(`IEE_OFS_CTRL, 32'h00000000, OK);
    poll_chk(32'h0, 32'h0, 1'b0);
    wr(`IEE_OFS_CTRL, 32'h80000000, OK);
    poll_chk(32'h1, 32'h0, 1'b0);
    poll_chk(32'h1, 32'h0, 1'b0);
    // each source gated off by its own bit, then let through alone
    for (int b = 0; b <= 28; b++) begin
      if (b != 27) begin
        wr(`IEE_OFS_CTRL, ~(32'h00000001 << b) & 32'h7FFFFFFF, OK);
        pulse(b);
        poll_chk(32'h0, 32'h0, 1'b0);
        wr(`IEE_OFS_CTRL, 32'h00000001 << b, OK);
        poll_chk(32'h1, 32'h1 << b, 1'b1);
        chk(psrc, 32'h1 << b);
      end
    end
    // lowest usb change flag must raise the same usb event
    wr(`IEE_OFS_CTRL, 32'h00100000, OK);
    pulse(30);
    poll_chk(32'h1, 32'h00100000, 1'b1);
    rdc(`IEE_OFS_STATUS, 32'h00000003, OK);
    rdc(`IEE_OFS_STATUS, 32'h00000000, OK);
    // masked and unmasked interrupt on a blocked poll
    wr(`IEE_OFS_MASK, 32'h00000001, OK);
    wr(`IEE_OFS_CTRL, 32'h00000000, OK);
    pulse(5);
    poll_chk(32'h0, 32'h0, 1'b0);
    irq_chk(1'b0);
    wr(`IEE_OFS_MASK, 32'h00000002, OK);
    irq_chk(1'b1);
    rdc(`IEE_OFS_PEND, 32'h00000020, OK);
    rdc(`IEE_OFS_STATUS, 32'h00000002, OK);
    irq_chk(1'b0);
    wr(`IEE_OFS_CTRL, 32'h00000020, OK);
    poll_chk(32'h1, 32'h00000020, 1'b1);
    irq_chk(1'b0);
    wr(`IEE_OFS_MASK, 32'h00000001, OK);
    irq_chk(1'b1);
    // sending poll with the sent bit unmasked raises the line again
    rdc(`IEE_OFS_STATUS, 32'h00000001, OK);
    irq_chk(1'b0);
    wr(`IEE_OFS_CTRL, 32'h80000000, OK);
    poll_chk(32'h1, 32'h0, 1'b0);
    irq_chk(1'b1);
    tally_and_finish();
  end
endmodule // iee_event_gate_bench

// *** sim/iee_host_model.sv ***
// host-side model that polls the interrupt endpoint
`timescale 1ns/1ps
module iee_host_model (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  output logic POLL_TICK,
  input wire logic PACKET_SEND,
  input wire logic [31:0] PACKET_SOURCES
);
  int sends = 0;
  logic [31:0] last_src = 32'h00000000;

  // count packets handed over and keep their source word
  always @(posedge CLK_SYS) begin
    if (RESETN && PACKET_SEND === 1'b1) begin
      sends <= sends + 1;
      last_src <= PACKET_SOURCES;
    end
  end

  initial POLL_TICK = 1'b0;

  // one interval tick; a long gap stands for a slow polling host
  task automatic poll(input int gap);
    @(posedge CLK_SYS);
    POLL_TICK <= 1'b1;
    @(posedge CLK_SYS);
    POLL_TICK <= 1'b0;
    repeat (gap + 3) @(posedge CLK_SYS);
  endtask
endmodule // iee_host_model
